// >>> air_link_model.sv
// behavioural radio link source that feeds whole frames into the receive pins
`timescale 1ns/1ns
`default_nettype none
module air_link_model (
	output var logic link_clk_out,
	output var logic link_dat_out,
	output var logic link_frame_out
);
	// link clock stands still low between frames
	initial begin
		link_clk_out = 1'b0;
		link_dat_out = 1'b1;
		link_frame_out = 1'b0;
	end

	// lsb first, data set in the low half of each 160 ns link period
	task automatic send_frame(input logic [7:0] b[$]);
		#5 link_frame_out = 1'b1; // keep every change off the sampling edge
		foreach (b[i]) begin
			for (int k = 0; k < 8; k++) begin
				link_dat_out = b[i][k];
				#80 link_clk_out = 1'b1;
				#80 link_clk_out = 1'b0;
			end
		end
		#80 link_frame_out = 1'b0;
		// released line shows the inverse so a stale bit is never reused
		link_dat_out = ~link_dat_out;
	endtask
endmodule
`default_nettype wire

// >>> radio_seq.sv
// transceiver state sequencer with frame transmit, receive and energy check
// Function
// - prep command from off: tune, supply, ready
// - receive command in prep enters receive
// - measurement write starts; done pulse, value readable
// - off command from prep returns off
// - auto checksum generated and sent by device
// - transmit starts from prep state, or from receive after an idle check
// - ramp, preamble, header, then buffer contents
// - after ramp down: end pulse, back prep
// - preamble detected freezes gain control
// - valid header: start pulse, start measurement
// - filter enabled and matching: match pulse
// - good frame: end pulse, go prep
// - bad frame: stay receive, release gain
// - receive length and buffer readable after
// - auto check compares threshold, sends if idle
// - done updates busy bit; idle passes prep
// - busy channel stays in receive
// - check procedure ends with end pulse, except an idle result after receive was left
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
module radio_seq #(
	parameter int BUF_DEPTH = 2048,
	parameter int ED_CYCLES = radio_seq_pkg::ED_CYC
) (
	input  wire logic        clock_in,
	input  wire logic        srst_in,
	input  wire logic [11:0] addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output var  logic [7:0]  rdata_out,
	input  wire logic        rx_clk_in,
	input  wire logic        rx_dat_in,
	input  wire logic        rx_frame_in,
	input  wire logic [7:0]  energy_in,
	output var  logic        tx_clk_out,
	output var  logic        tx_dat_out,
	output var  logic        pa_en_out,
	output var  logic        supply_en_out,
	output var  logic        agc_hold_out,
	output var  logic        ready_irq_out,
	output var  logic        energy_done_irq_out,
	output var  logic        tx_end_irq_out,
	output var  logic        rx_start_irq_out,
	output var  logic        address_match_irq_out,
	output var  logic        rx_end_irq_out
);
	localparam int AW = $clog2(BUF_DEPTH);

	if (BUF_DEPTH < 4 || BUF_DEPTH > 2048 || (1 << AW) != BUF_DEPTH) begin : g_bad_depth
		$error("BUF_DEPTH must be a power of two from 4 to 2048");
	end
	if (ED_CYCLES < 1) begin : g_bad_ed
		$error("ED_CYCLES must be at least one");
	end

	radio_seq_pkg::state_t state_r, state_nxt;
	logic [7:0]  ctrl_r, thr_r, faddr_r, txll_r, txlh_r, rxll_r, rxlh_r, edv_r;
	logic [7:0]  tx_mem [BUF_DEPTH];
	logic [7:0]  rx_mem [BUF_DEPTH];
	logic [15:0] tmr_r, idx_r, rcnt_r, rlen_r;
	logic [31:0] ed_cnt_r;
	logic [7:0]  ed_max_r, sh_r, rsh_r, rchk_r, chk_r, rd_mux;
	logic [2:0]  bit_r, rbit_r;
	logic [3:0]  div_r;
	logic        busy_r, ed_run_r, ed_auto_r, rx_on_r, rclk_d_r, rfrm_d_r;
	logic        rx_clk_s, rx_dat_s, rx_frame_s;
	logic [7:0]  energy_s, energy_d_r, energy_q_r;

	// every link pin passes two flops before use
	sync2 #(.WIDTH(3)) u_sync_link (
		.clock_in(clock_in),
		.srst_in (srst_in),
		.async_in({rx_clk_in, rx_dat_in, rx_frame_in}),
		.sync_out({rx_clk_s, rx_dat_s, rx_frame_s})
	);
	sync2 #(.WIDTH(8)) u_sync_energy (
		.clock_in(clock_in),
		.srst_in (srst_in),
		.async_in(energy_in),
		.sync_out(energy_s)
	);

	// bus decode
	wire        buf_sel  = addr_in[radio_seq_pkg::BUF_SEL];
	wire        cmd_wr   = wr_in && addr_in == radio_seq_pkg::REG_CMD;
	wire        ctrl_wr  = wr_in && addr_in == radio_seq_pkg::REG_CTRL;
	wire        in_rx    = state_r == radio_seq_pkg::ST_RX;
	wire        tmr_zero = tmr_r == 16'h0000;
	wire [15:0] tx_len   = {txlh_r, txll_r};
	wire        tx_act   = state_r == radio_seq_pkg::ST_PRE || state_r == radio_seq_pkg::ST_HDR
		|| state_r == radio_seq_pkg::ST_PAY;
	wire        bit_en   = tx_act && div_r == 4'(radio_seq_pkg::TX_DIV - 1);
	wire        byte_done = bit_en && bit_r == 3'h7;

	// energy measurement, host start only in receive; header start is automatic
	wire edm_wr  = wr_in && addr_in == radio_seq_pkg::REG_EDM
		&& wdata_in == radio_seq_pkg::EDM_START && in_rx;
	wire ed_done = ed_run_r && ed_cnt_r == 32'(ED_CYCLES - 1);
	wire ed_busy = ed_max_r >= thr_r; // equal to threshold counts as busy
	wire cts_eval = ed_done && !ed_auto_r && ctrl_r[radio_seq_pkg::CTRL_CTS];
	wire cts_go   = cts_eval && !ed_busy && in_rx;
	wire cts_busy = cts_eval && ed_busy;

	// receive byte assembly on rising link clock edges
	wire        rclk_rise = rx_clk_s && !rclk_d_r;
	wire        rx_en     = in_rx && ctrl_r[radio_seq_pkg::CTRL_BBEN];
	wire        pre_det   = rx_en && rx_frame_s && !rfrm_d_r && !rx_on_r; // envelope rise only
	wire        byte_got  = rx_on_r && rclk_rise && rbit_r == 3'h7;
	wire [7:0]  rbyte     = {rx_dat_s, rsh_r[7:1]};
	wire [15:0] hlen      = {rbyte, rlen_r[7:0]};
	wire        hdr_ok    = byte_got && rcnt_r == 16'h0001
		&& hlen >= 16'(radio_seq_pkg::CHK_OCT) && hlen <= 16'(BUF_DEPTH);
	wire        hdr_bad   = byte_got && rcnt_r == 16'h0001 && !hdr_ok;
	wire [15:0] pidx      = rcnt_r - 16'h0002;
	wire        pay_byte  = byte_got && rcnt_r >= 16'h0002;
	wire        last_byte = pay_byte && pidx == rlen_r - 16'h0001;
	wire        rx_good   = last_byte && (rchk_r ^ rbyte) == 8'h00;
	wire        rx_bad    = (last_byte && !rx_good) || hdr_bad || (rx_on_r && !rx_frame_s)
		|| (rx_on_r && !in_rx);
	wire        amatch    = pay_byte && pidx == 16'h0000 && ctrl_r[radio_seq_pkg::CTRL_FILT]
		&& rbyte == faddr_r;

	// state transitions; anything not listed is ignored
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			radio_seq_pkg::ST_OFF: begin
				if (cmd_wr && wdata_in == radio_seq_pkg::CMD_PREP)
					state_nxt = radio_seq_pkg::ST_TUNE;
			end
			radio_seq_pkg::ST_TUNE: begin
				if (tmr_zero)
					state_nxt = radio_seq_pkg::ST_PREP;
			end
			radio_seq_pkg::ST_PREP: begin
				if (cmd_wr && wdata_in == radio_seq_pkg::CMD_RX)
					state_nxt = radio_seq_pkg::ST_RX;
				else if (cmd_wr && wdata_in == radio_seq_pkg::CMD_OFF)
					state_nxt = radio_seq_pkg::ST_OFF;
				else if (cmd_wr && wdata_in == radio_seq_pkg::CMD_TX)
					state_nxt = radio_seq_pkg::ST_RUP;
			end
			radio_seq_pkg::ST_RX: begin
				if (rx_good)
					state_nxt = radio_seq_pkg::ST_PREP;
				else if (cts_go)
					state_nxt = radio_seq_pkg::ST_RUP;
				else if (cmd_wr && wdata_in == radio_seq_pkg::CMD_PREP)
					state_nxt = radio_seq_pkg::ST_PREP;
			end
			radio_seq_pkg::ST_RUP: begin
				if (tmr_zero)
					state_nxt = radio_seq_pkg::ST_PRE;
			end
			radio_seq_pkg::ST_PRE: begin
				if (byte_done && idx_r == 16'(radio_seq_pkg::PRE_BYTES - 1))
					state_nxt = radio_seq_pkg::ST_HDR;
			end
			radio_seq_pkg::ST_HDR: begin
				if (byte_done && idx_r == 16'h0001)
					state_nxt = radio_seq_pkg::ST_PAY;
			end
			radio_seq_pkg::ST_PAY: begin
				if (byte_done && idx_r == tx_len - 16'h0001)
					state_nxt = radio_seq_pkg::ST_RDN;
			end
			radio_seq_pkg::ST_RDN: begin
				if (tmr_zero)
					state_nxt = radio_seq_pkg::ST_PREP;
			end
			default: state_nxt = radio_seq_pkg::ST_OFF;
		endcase
	end

	wire st_chg   = state_nxt != state_r;
	wire ready_ev = (state_r == radio_seq_pkg::ST_TUNE && tmr_zero) || cts_go
		|| (in_rx && state_nxt == radio_seq_pkg::ST_PREP && !rx_good);
	wire txend_ev = (state_r == radio_seq_pkg::ST_RDN && tmr_zero) || cts_busy;

	// next transmit byte for the coming position
	wire [15:0] idx_nxt = st_chg ? 16'h0000 : idx_r + 16'h0001;
	wire        load    = (st_chg && state_nxt == radio_seq_pkg::ST_PRE) || (byte_done && tx_act);
	wire        chk_pos = ctrl_r[radio_seq_pkg::CTRL_ACHK] && idx_nxt == tx_len - 16'h0001;
	wire [7:0]  nbyte   = state_nxt == radio_seq_pkg::ST_PRE ? radio_seq_pkg::PREAMBLE
		: state_nxt == radio_seq_pkg::ST_HDR ? (idx_nxt == 16'h0000 ? txll_r : txlh_r)
		: chk_pos ? chk_r : tx_mem[idx_nxt[AW-1:0]];

	// state, timer and transmit position
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			state_r <= radio_seq_pkg::ST_OFF;
			tmr_r   <= 16'h0000;
			idx_r   <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			if (st_chg && state_nxt == radio_seq_pkg::ST_TUNE)
				tmr_r <= 16'(radio_seq_pkg::TUNE_CYC - 1);
			else if (st_chg && (state_nxt == radio_seq_pkg::ST_RUP
				|| state_nxt == radio_seq_pkg::ST_RDN))
				tmr_r <= 16'(radio_seq_pkg::RAMP_CYC - 1);
			else if (!tmr_zero)
				tmr_r <= tmr_r - 16'h0001;
			if (st_chg || byte_done)
				idx_r <= idx_nxt;
		end
	end

	// serialiser and bit clock divider
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			div_r <= 4'h0;
			bit_r <= 3'h0;
			sh_r  <= 8'h00;
			chk_r <= 8'h00;
		end else begin
			div_r <= (!tx_act || bit_en) ? 4'h0 : div_r + 4'h1;
			if (load) begin
				sh_r  <= nbyte;
				bit_r <= 3'h0;
				if (state_nxt == radio_seq_pkg::ST_PAY)
					chk_r <= (st_chg ? 8'h00 : chk_r) ^ nbyte;
			end else if (bit_en) begin
				sh_r  <= sh_r >> 1;
				bit_r <= bit_r + 3'h1;
			end
		end
	end

	// receive path
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			rclk_d_r     <= 1'b0;
			rfrm_d_r     <= 1'b0;
			rx_on_r      <= 1'b0;
			agc_hold_out <= 1'b0;
			rbit_r       <= 3'h0;
			rsh_r        <= 8'h00;
			rcnt_r       <= 16'h0000;
			rlen_r       <= 16'h0000;
			rchk_r       <= 8'h00;
			rxll_r       <= 8'h00;
			rxlh_r       <= 8'h00;
		end else begin
			rclk_d_r <= rx_clk_s;
			rfrm_d_r <= rx_frame_s;
			if (pre_det) begin
				rx_on_r      <= 1'b1;
				agc_hold_out <= 1'b1;
				rbit_r       <= 3'h0;
				rcnt_r       <= 16'h0000;
				rchk_r       <= 8'h00;
			end else if (rx_bad || rx_good) begin
				rx_on_r      <= 1'b0;
				agc_hold_out <= 1'b0;
			end else if (rx_on_r && rclk_rise) begin
				rsh_r  <= rbyte;
				rbit_r <= rbit_r + 3'h1;
			end
			if (byte_got && !rx_bad) begin
				rcnt_r <= rcnt_r + 16'h0001;
				if (rcnt_r == 16'h0000)
					rlen_r[7:0] <= rbyte;
				else if (rcnt_r == 16'h0001)
					rlen_r <= hlen;
				else
					rchk_r <= rchk_r ^ rbyte;
			end
			if (rx_good) begin
				rxll_r <= rlen_r[7:0];
				rxlh_r <= rlen_r[15:8];
			end
		end
	end

	// buffers keep no reset; frame bytes land from index zero
	always_ff @(posedge clock_in) begin
		if (wr_in && buf_sel)
			tx_mem[addr_in[AW-1:0]] <= wdata_in;
		if (pay_byte && !hdr_bad)
			rx_mem[pidx[AW-1:0]] <= rbyte;
	end

	// a level word from another domain is trusted only once two samples agree
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			energy_d_r <= 8'h00;
			energy_q_r <= 8'h00;
		end else begin
			energy_d_r <= energy_s;
			if (energy_s == energy_d_r)
				energy_q_r <= energy_s;
		end
	end

	// energy measurement keeps the peak seen over the window
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			ed_run_r  <= 1'b0;
			ed_auto_r <= 1'b0;
			ed_cnt_r  <= 32'h0;
			ed_max_r  <= 8'h00;
			edv_r     <= 8'h00;
			busy_r    <= 1'b0;
		end else if (edm_wr || hdr_ok) begin
			ed_run_r  <= 1'b1;
			ed_auto_r <= hdr_ok;
			ed_cnt_r  <= 32'h0;
			ed_max_r  <= energy_q_r;
		end else if (ed_run_r) begin
			ed_cnt_r <= ed_cnt_r + 32'h1;
			if (energy_q_r > ed_max_r)
				ed_max_r <= energy_q_r;
			if (ed_done) begin
				ed_run_r <= 1'b0;
				edv_r    <= ed_max_r;
				if (cts_eval)
					busy_r <= ed_busy;
			end
		end
	end

	// host registers; hardware re-enabling baseband wins over a host write
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			ctrl_r  <= radio_seq_pkg::CTRL_RST;
			thr_r   <= radio_seq_pkg::THR_RST;
			faddr_r <= radio_seq_pkg::FADDR_RST;
			txll_r  <= 8'h00;
			txlh_r  <= 8'h00;
		end else begin
			if (ctrl_wr)
				ctrl_r <= wdata_in;
			if (cts_go)
				ctrl_r[radio_seq_pkg::CTRL_BBEN] <= 1'b1;
			if (wr_in && addr_in == radio_seq_pkg::REG_THR)
				thr_r <= wdata_in;
			if (wr_in && addr_in == radio_seq_pkg::REG_FADDR)
				faddr_r <= wdata_in;
			if (wr_in && addr_in == radio_seq_pkg::REG_TXLL)
				txll_r <= wdata_in;
			if (wr_in && addr_in == radio_seq_pkg::REG_TXLH)
				txlh_r <= wdata_in;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		case (addr_in)
			radio_seq_pkg::REG_STATE: rd_mux = {4'h0, state_r};
			radio_seq_pkg::REG_CTRL:  rd_mux = ctrl_r;
			radio_seq_pkg::REG_EDV:   rd_mux = edv_r;
			radio_seq_pkg::REG_THR:   rd_mux = thr_r;
			radio_seq_pkg::REG_TXLL:  rd_mux = txll_r;
			radio_seq_pkg::REG_TXLH:  rd_mux = txlh_r;
			radio_seq_pkg::REG_RXLL:  rd_mux = rxll_r;
			radio_seq_pkg::REG_RXLH:  rd_mux = rxlh_r;
			radio_seq_pkg::REG_FADDR: rd_mux = faddr_r;
			radio_seq_pkg::REG_STAT:  rd_mux = {5'h00, ed_run_r, agc_hold_out, busy_r};
			default:                  rd_mux = buf_sel ? rx_mem[addr_in[AW-1:0]] : 8'h00;
		endcase
	end

	// registered outputs and one-cycle event pulses
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			rdata_out             <= 8'h00;
			tx_clk_out            <= 1'b0;
			tx_dat_out            <= 1'b0;
			pa_en_out             <= 1'b0;
			supply_en_out         <= 1'b0;
			ready_irq_out         <= 1'b0;
			energy_done_irq_out   <= 1'b0;
			tx_end_irq_out        <= 1'b0;
			rx_start_irq_out      <= 1'b0;
			address_match_irq_out <= 1'b0;
			rx_end_irq_out        <= 1'b0;
		end else begin
			rdata_out             <= rd_in ? rd_mux : 8'h00;
			tx_clk_out            <= tx_act && div_r >= 4'(radio_seq_pkg::TX_DIV / 2);
			tx_dat_out            <= tx_act && sh_r[0];
			pa_en_out             <= state_nxt >= radio_seq_pkg::ST_RUP;
			supply_en_out         <= state_nxt != radio_seq_pkg::ST_OFF;
			ready_irq_out         <= ready_ev;
			energy_done_irq_out   <= ed_done && !ed_auto_r;
			tx_end_irq_out        <= txend_ev;
			rx_start_irq_out      <= hdr_ok;
			address_match_irq_out <= amatch;
			rx_end_irq_out        <= rx_good;
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (srst_in);

	a_off_tune: assert property ((state_r == radio_seq_pkg::ST_OFF && cmd_wr
		&& wdata_in == radio_seq_pkg::CMD_PREP) |=> state_r == radio_seq_pkg::ST_TUNE
		##[1:200] (state_r == radio_seq_pkg::ST_PREP && ready_irq_out)) else $error("no ready");
	a_prep_rx: assert property ((state_r == radio_seq_pkg::ST_PREP && cmd_wr
		&& wdata_in == radio_seq_pkg::CMD_RX) |=> in_rx) else $error("rx not entered");
	a_ed_value: assert property (energy_done_irq_out |-> edv_r == $past(ed_max_r)
		&& !ed_run_r) else $error("energy value wrong");
	a_prep_off: assert property ((state_r == radio_seq_pkg::ST_PREP && cmd_wr
		&& wdata_in == radio_seq_pkg::CMD_OFF) |=> state_r == radio_seq_pkg::ST_OFF
		&& !supply_en_out) else $error("off not reached");
	a_tx_entry: assert property ($rose(state_r == radio_seq_pkg::ST_RUP)
		|-> $past(state_r) == radio_seq_pkg::ST_PREP || $past(cts_go)) else $error("bad tx start");
	a_tx_end: assert property ($fell(state_r == radio_seq_pkg::ST_RDN)
		|-> state_r == radio_seq_pkg::ST_PREP && tx_end_irq_out) else $error("no tx end");
	a_agc_freeze: assert property (pre_det |=> agc_hold_out) else $error("agc not held");
	a_rx_end: assert property (rx_good |=> rx_end_irq_out
		&& state_r == radio_seq_pkg::ST_PREP && !agc_hold_out) else $error("rx end wrong");
	a_rx_bad: assert property ((rx_bad && !rx_good && in_rx && !cts_go && !cmd_wr)
		|=> in_rx && !agc_hold_out && !rx_end_irq_out) else $error("bad frame left rx");
	a_cts_busy: assert property (cts_busy && in_rx && !rx_good && !cmd_wr
		|=> in_rx && busy_r && tx_end_irq_out) else $error("busy handling wrong");
	a_cts_idle: assert property (cts_go |=> ready_irq_out
		&& !busy_r && ctrl_r[radio_seq_pkg::CTRL_BBEN] && state_r == radio_seq_pkg::ST_RUP)
		else $error("idle handling wrong");
	a_cmd_ignore: assert property ((state_r == radio_seq_pkg::ST_OFF && cmd_wr
		&& wdata_in != radio_seq_pkg::CMD_PREP) |=> state_r == radio_seq_pkg::ST_OFF
		&& !ready_irq_out) else $error("ignored command acted");

	c_tx_frame: cover property (tx_end_irq_out && $past(state_r) == radio_seq_pkg::ST_RDN);
	c_rx_frame: cover property (rx_end_irq_out);
	c_cts_busy: cover property (cts_busy);
	c_cts_idle: cover property (cts_go);
endmodule
`default_nettype wire

// >>> radio_seq_pkg.sv
// shared constants, register map and state codes for the radio frame sequencer
package radio_seq_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	// register map (word per register, buffers in the upper half)
	localparam logic [11:0] REG_CMD   = 12'h000;
	localparam logic [11:0] REG_STATE = 12'h001;
	localparam logic [11:0] REG_CTRL  = 12'h002;
	localparam logic [11:0] REG_EDM   = 12'h003;
	localparam logic [11:0] REG_EDV   = 12'h004;
	localparam logic [11:0] REG_THR   = 12'h005;
	localparam logic [11:0] REG_TXLL  = 12'h006;
	localparam logic [11:0] REG_TXLH  = 12'h007;
	localparam logic [11:0] REG_RXLL  = 12'h008;
	localparam logic [11:0] REG_RXLH  = 12'h009;
	localparam logic [11:0] REG_STAT  = 12'h00a;
	localparam logic [11:0] REG_FADDR = 12'h00b;
	localparam int          BUF_SEL   = 11;

	// control register fields
	localparam int         CTRL_BBEN = 0;
	localparam int         CTRL_ACHK = 1;
	localparam int         CTRL_CTS  = 2;
	localparam int         CTRL_FILT = 3;
	localparam int         CTRL_AACK = 4;
	localparam int         CTRL_S2L  = 5;
	localparam logic [7:0] CTRL_RST  = 8'h03;
	localparam logic [7:0] THR_RST   = 8'h00;
	localparam logic [7:0] FADDR_RST = 8'h00;

	// status register fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_AGC  = 1;
	localparam int STAT_EDR  = 2;

	// commands and measurement mode
	localparam logic [7:0] CMD_OFF   = 8'h02;
	localparam logic [7:0] CMD_PREP  = 8'h03;
	localparam logic [7:0] CMD_TX    = 8'h04;
	localparam logic [7:0] CMD_RX    = 8'h05;
	localparam logic [7:0] EDM_START = 8'h01;

	typedef enum logic [3:0] {
		ST_OFF  = 4'h0,
		ST_TUNE = 4'h1,
		ST_PREP = 4'h2,
		ST_RX   = 4'h3,
		ST_RUP  = 4'h4,
		ST_PRE  = 4'h5,
		ST_HDR  = 4'h6,
		ST_PAY  = 4'h7,
		ST_RDN  = 4'h8
	} state_t;

	// frame format
	localparam logic [7:0] PREAMBLE  = 8'h55;
	localparam int         PRE_BYTES = 4;
	localparam int         CHK_OCT   = 1;

	// timing
	localparam int CLK_MHZ        = 50;
	localparam int TUNE_TIME_NS   = 2000;
	localparam int TUNE_CYC       = (TUNE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int RAMP_TIME_NS   = 4000;
	localparam int RAMP_CYC       = (RAMP_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int ED_TIME_US     = 960;
	localparam int ED_CYC         = ED_TIME_US * CLK_MHZ;
	localparam int LINK_PERIOD_NS = 160;
	localparam int TX_DIV         = LINK_PERIOD_NS * CLK_MHZ / 1000;
endpackage

// >>> radio_seq_tb.sv
// self-checking bench for the radio frame sequencer
`timescale 1ns/1ns
`default_nettype none
module radio_seq_tb;
	logic        clock_in;
	logic        srst_in;
	logic [11:0] addr_in;
	logic [7:0]  wdata_in;
	logic        wr_in;
	logic        rd_in;
	logic [7:0]  rdata_out;
	logic        rx_clk_in;
	logic        rx_dat_in;
	logic        rx_frame_in;
	logic [7:0]  energy_in;
	logic        tx_clk_out;
	logic        tx_dat_out;
	logic        pa_en_out;
	logic        supply_en_out;
	logic        agc_hold_out;
	wire [5:0]   irq;
	logic        tck_q;
	logic        agc_seen;
	logic [7:0]  cur;
	logic [7:0]  txq[$];
	logic [7:0]  exp_tx[9] = '{8'h55, 8'h55, 8'h55, 8'h55, 8'h03, 8'h00, 8'ha1, 8'hb2, 8'h13};
	int          cnt[6];
	int          nbit;
	int          cyc;
	int          r0;
	int          errors;
	int          samples_checked;

	radio_seq #(.ED_CYCLES(20)) radio_seq_i (
		.clock_in(clock_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rx_clk_in(rx_clk_in),
		.rx_dat_in(rx_dat_in), .rx_frame_in(rx_frame_in), .energy_in(energy_in),
		.tx_clk_out(tx_clk_out), .tx_dat_out(tx_dat_out), .pa_en_out(pa_en_out),
		.supply_en_out(supply_en_out), .agc_hold_out(agc_hold_out),
		.ready_irq_out(irq[0]), .energy_done_irq_out(irq[1]), .tx_end_irq_out(irq[2]),
		.rx_start_irq_out(irq[3]), .address_match_irq_out(irq[4]), .rx_end_irq_out(irq[5])
	);

	air_link_model air_link_model_i (
		.link_clk_out(rx_clk_in), .link_dat_out(rx_dat_in), .link_frame_out(rx_frame_in)
	);

	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end

	// pulse counts, gain-hold latch and bit capture, sampled mid-cycle once settled
	always @(negedge clock_in) begin
		cyc++;
		for (int i = 0; i < 6; i++) begin
			if (irq[i] === 1'b1) cnt[i]++;
		end
		if (agc_hold_out === 1'b1) agc_seen = 1'b1;
		if (tx_clk_out === 1'b1 && tck_q === 1'b0) begin
			cur = {tx_dat_out, cur[7:1]};
			nbit++;
			if (nbit % 8 == 0) txq.push_back(cur);
		end
		tck_q = tx_clk_out;
		if (cyc == 40000) begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe edge
	task automatic rchk(input logic [11:0] a, input logic [7:0] e, input string m);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 chk(rdata_out, e, m);
	endtask

	task automatic cmd(input logic [7:0] c);
		wr(radio_seq_pkg::REG_CMD, c);
	endtask

	task automatic st(input logic [7:0] e);
		rchk(radio_seq_pkg::REG_STATE, e, "state");
	endtask

	// bounded wait on a pulse counter; a miss shows as a count mismatch
	task automatic wcnt(input int i, input int n);
		for (int k = 0; k < 5000 && cnt[i] < n; k++) @(posedge clock_in);
		#1 chk(8'(cnt[i]), 8'(n), "pulse count");
	endtask

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		srst_in = 1'b1;
		addr_in = 12'h000;
		wdata_in = 8'h00;
		wr_in = 1'b0;
		rd_in = 1'b0;
		energy_in = 8'h00;
		repeat (12) @(posedge clock_in);
		srst_in <= 1'b0;
		rchk(radio_seq_pkg::REG_CTRL, radio_seq_pkg::CTRL_RST, "ctrl reset");
		rchk(12'h0ff, 8'h00, "unmapped");
		cmd(radio_seq_pkg::CMD_TX);
		cmd(radio_seq_pkg::CMD_RX);
		st(8'h00);
		chk(8'(cnt[0] + cnt[2]), 8'h00, "stray pulse");
		done("reset and refused commands");
		cmd(radio_seq_pkg::CMD_PREP);
		st(8'h01);
		wcnt(0, 1);
		st(8'h02);
		chk({7'h00, supply_en_out}, 8'h01, "supply on");
		cmd(radio_seq_pkg::CMD_RX);
		st(8'h03);
		energy_in <= 8'h3c;
		wr(radio_seq_pkg::REG_CTRL, 8'h02);
		wr(radio_seq_pkg::REG_EDM, radio_seq_pkg::EDM_START);
		wcnt(1, 1);
		rchk(radio_seq_pkg::REG_EDV, 8'h3c, "energy value");
		wr(radio_seq_pkg::REG_CTRL, 8'h03);
		cmd(radio_seq_pkg::CMD_PREP);
		wcnt(0, 2);
		cmd(radio_seq_pkg::CMD_OFF);
		st(8'h00);
		chk({7'h00, supply_en_out}, 8'h00, "supply off");
		done("state commands and energy");
		cmd(radio_seq_pkg::CMD_PREP);
		wcnt(0, 3);
		wr(radio_seq_pkg::REG_TXLL, 8'h03);
		wr(radio_seq_pkg::REG_TXLH, 8'h00);
		wr(12'h800, 8'ha1);
		wr(12'h801, 8'hb2);
		nbit = 0;
		txq.delete();
		cmd(radio_seq_pkg::CMD_TX);
		wcnt(2, 1);
		foreach (exp_tx[i]) chk(txq[i], exp_tx[i], "tx byte");
		st(8'h02);
		chk({7'h00, pa_en_out}, 8'h00, "amplifier off");
		done("transmit");
		wr(radio_seq_pkg::REG_FADDR, 8'ha5);
		wr(radio_seq_pkg::REG_CTRL, 8'h0b);
		cmd(radio_seq_pkg::CMD_RX);
		agc_seen = 1'b0;
		air_link_model_i.send_frame('{8'h03, 8'h00, 8'ha5, 8'h5a, 8'hff});
		wcnt(5, 1);
		chk({7'h00, agc_seen}, 8'h01, "gain frozen");
		chk(8'(cnt[3]), 8'h01, "rx start");
		chk(8'(cnt[4]), 8'h01, "address match");
		st(8'h02);
		rchk(radio_seq_pkg::REG_RXLL, 8'h03, "rx len low");
		rchk(radio_seq_pkg::REG_RXLH, 8'h00, "rx len high");
		rchk(12'h800, 8'ha5, "rx byte 0");
		rchk(12'h801, 8'h5a, "rx byte 1");
		rchk(12'h802, 8'hff, "rx byte 2");
		cmd(radio_seq_pkg::CMD_RX);
		agc_seen = 1'b0;
		air_link_model_i.send_frame('{8'h02, 8'h00, 8'h11, 8'h22});
		repeat (20) @(posedge clock_in);
		chk(8'(cnt[5]), 8'h01, "no rx end");
		st(8'h03);
		chk({6'h00, agc_seen, agc_hold_out}, 8'h02, "gain released");
		done("receive");
		wr(radio_seq_pkg::REG_CTRL, 8'h06);
		wr(radio_seq_pkg::REG_THR, 8'h40);
		energy_in <= 8'h10;
		r0 = cnt[0];
		nbit = 0;
		txq.delete();
		wr(radio_seq_pkg::REG_EDM, radio_seq_pkg::EDM_START);
		wcnt(2, 2);
		chk(8'(cnt[0]), 8'(r0 + 1), "ready on idle");
		foreach (exp_tx[i]) chk(txq[i], exp_tx[i], "auto tx byte");
		rchk(radio_seq_pkg::REG_STAT, 8'h00, "idle status");
		rchk(radio_seq_pkg::REG_CTRL, 8'h07, "baseband back on");
		cmd(radio_seq_pkg::CMD_RX);
		wr(radio_seq_pkg::REG_CTRL, 8'h06);
		energy_in <= 8'h40;
		wr(radio_seq_pkg::REG_EDM, radio_seq_pkg::EDM_START);
		wcnt(2, 3);
		chk(8'(cnt[0]), 8'(r0 + 1), "no ready on busy");
		rchk(radio_seq_pkg::REG_STAT, 8'h01, "busy status");
		st(8'h03);
		done("check then send");
		tally_and_finish();
	end
endmodule
`default_nettype wire

// >>> sync2.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock_in,
	input  wire logic             srst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire
